// [logic/err_pkg.sv]
// ****************************************************************
// Overview of operation
// - Flag any deviation from correct service
// - Lost poison counts as a detected error
// - Coherency loss counts as a detected error
// - Poisoned line partially written becomes modified
// - Partial write keeps granule poison intact
// - Error or poisoned responses are consumed errors
// - Report every error to a recording node
// - Report carries originating component and syndrome
// - Correct correctable errors, report as Corrected
// - Corrected read returns corrected data
// - Deferrable error poisons data, reported Deferred
// - Deferred/uncorrected raise enabled fault and recovery
// - Never defer to consumer refusing poison
// - Non-deferrable uncorrectable errors reported Uncorrected
// - Uncorrected consumer read gets in-band error
// - Fatal uncorrected error may enter service failure
// - Recording node captures syndrome in record
// - Record survives error recovery reset
// - Later error overwrites shared record syndrome
// ****************************************************************
package err_pkg;
   // Widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int SYN_W = 16;
   localparam int LINES = 4;
   localparam int IDX_W = 2;
   localparam int NCLS = 3;

   // Class index into pending vectors, lowest severity first
   localparam int CLS_CE = 0;
   localparam int CLS_DE = 1;
   localparam int CLS_UE = 2;

   // Recorded component error state
   typedef enum logic [1:0] {
      ST_NONE = 2'b00,
      ST_CE = 2'b01,
      ST_DE = 2'b10,
      ST_UE = 2'b11
   } err_state_e;

   // Syndrome layout: {source, cause, address}
   localparam int SYN_SRC_LSB = 12;
   localparam int SYN_CAUSE_LSB = 8;
   localparam int SYN_ADDR_LSB = 0;

   // Originating component id, value arbitrary
   localparam logic [3:0] SRC_ID = 4'h5;

   // Cause codes
   localparam logic [3:0] CAUSE_CORR = 4'h1;
   localparam logic [3:0] CAUSE_DEFER = 4'h2;
   localparam logic [3:0] CAUSE_UNCORR = 4'h3;
   localparam logic [3:0] CAUSE_CONS_POISON = 4'h4;
   localparam logic [3:0] CAUSE_CONS_ABORT = 4'h5;
   localparam logic [3:0] CAUSE_DEVIATION = 4'h6;
   localparam logic [3:0] CAUSE_POISON_LOST = 4'h7;
   localparam logic [3:0] CAUSE_COH_LOSS = 4'h8;

   // Reset values
   localparam logic [SYN_W-1:0] RST_SYN = 16'h0000;
   localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] RST_ADDR = 8'h00;
   localparam logic [IDX_W-1:0] RST_IDX = 2'h0;
endpackage

// [logic/line_poison_state.sv]
`timescale 1ns/1ps
`default_nettype none
// Poison and ownership state of one cache line
module line_poison_state
   import err_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic fill, // Line filled from memory
   input wire logic fill_poison, // Fill data carried poison
   input wire logic wr, // Write to the line
   input wire logic wr_full, // Write covers the whole granule
   input wire logic evict, // Line evicted
   output logic poison_q, // Line holds poison
   output logic modified_q // Line owned and dirty
);
   logic poison_d;
   logic modified_d;

   // Fill wins over write, write over evict
   always_comb begin
      poison_d = poison_q;
      modified_d = modified_q;
      if (fill) begin
         poison_d = fill_poison;
         modified_d = 1'b0;
      end else if (wr) begin
         // Only a full granule write can clean poison
         poison_d = poison_q & ~wr_full;
         // Taking ownership makes eviction write the poison back
         modified_d = 1'b1;
      end else if (evict) begin
         poison_d = 1'b0;
         modified_d = 1'b0;
      end
   end

   // State flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         poison_q <= 1'b0;
         modified_q <= 1'b0;
      end else begin
         poison_q <= poison_d;
         modified_q <= modified_d;
      end
   end
endmodule
`default_nettype wire

// [logic/severity_pick.sv]
`timescale 1ns/1ps
`default_nettype none
// Picks the most severe pending class
module severity_pick
   import err_pkg::*;
(
   input wire logic [NCLS-1:0] pend, // Pending classes
   output logic [NCLS-1:0] gnt, // One-hot grant
   output err_pkg::err_state_e state // State of granted class
);
   // Fixed priority: Uncorrected, Deferred, Corrected
   assign gnt[CLS_UE] = pend[CLS_UE];
   assign gnt[CLS_DE] = pend[CLS_DE] & ~pend[CLS_UE];
   assign gnt[CLS_CE] = pend[CLS_CE] & ~pend[CLS_DE] & ~pend[CLS_UE];
   assign state = gnt[CLS_UE] ? ST_UE : gnt[CLS_DE] ? ST_DE : gnt[CLS_CE] ? ST_CE : ST_NONE;
endmodule
`default_nettype wire

// [logic/error_detect_classify_report.sv]
`timescale 1ns/1ps
`default_nettype none
module error_detect_classify_report
   import err_pkg::*;
(
   input wire logic mclk, // Clock, 125 MHz
   input wire logic rst_n, // Async reset, active low
   input wire logic err_rec_rst, // Error recovery reset pulse
   // Consumer access with check result
   input wire logic acc_valid, // Access presented
   input wire logic acc_read, // Access is a read
   input wire logic acc_spec, // Access is speculative
   input wire logic [err_pkg::ADDR_W-1:0] acc_addr, // Access address
   input wire logic [err_pkg::DATA_W-1:0] acc_data, // Raw stored data
   input wire logic [err_pkg::DATA_W-1:0] acc_corr_data, // Corrected data
   input wire logic acc_ce, // Correctable error seen
   input wire logic acc_uncorr, // Uncorrectable error seen
   input wire logic acc_defer_ok, // Error can be deferred
   input wire logic cons_poison_ok, // Consumer accepts poison
   // Responses to transactions this block initiated
   input wire logic rsp_valid, // Response returned
   input wire logic rsp_err, // In-band error response
   input wire logic rsp_poison, // Poisoned response
   input wire logic [err_pkg::ADDR_W-1:0] rsp_addr, // Response address
   // Other detectors
   input wire logic dev_err, // Service deviation seen
   input wire logic poison_drop, // Poison lost at a boundary
   input wire logic coh_loss, // Coherency lost
   input wire logic [err_pkg::ADDR_W-1:0] det_addr, // Address of detection
   // Cache line operations
   input wire logic fill_valid, // Line fill
   input wire logic fill_poison, // Fill carried poison
   input wire logic pwr_valid, // Write to line
   input wire logic pwr_full, // Write covers whole granule
   input wire logic evict_valid, // Line eviction
   input wire logic [err_pkg::IDX_W-1:0] line_idx, // Line index of op
   // Enables
   input wire logic rpt_ce_en, // Report corrected errors
   input wire logic rpt_spec_en, // Report speculative detections
   input wire logic fhi_en, // Fault handling interrupt enable
   input wire logic eri_en, // Error recovery interrupt enable
   input wire logic inband_en, // In-band error response enable
   input wire logic halt_on_ue, // Halt on uncorrected error
   input wire logic rec_clr, // Clear the error record
   // Read answer to consumer
   output logic rd_valid_q, // Read answer
   output logic [err_pkg::DATA_W-1:0] rd_data_q, // Read data
   output logic rd_poison_q, // Read data poisoned
   output logic rd_err_q, // In-band error response
   output logic poison_set_q, // Poison the written location
   output logic [err_pkg::ADDR_W-1:0] poison_addr_q, // Location to poison
   // Report to recording node
   output logic rpt_valid_q, // Report pulse
   output err_pkg::err_state_e rpt_state_q, // Reported error state
   output logic [err_pkg::SYN_W-1:0] rpt_syn_q, // Reported syndrome
   output logic fault_irq_q, // Fault handling interrupt pulse
   output logic recov_irq_q, // Error recovery interrupt pulse
   // Local error record
   output logic rec_valid_q, // Record holds an error
   output err_pkg::err_state_e rec_state_q, // Recorded state
   output logic [err_pkg::SYN_W-1:0] rec_syn_q, // Recorded syndrome
   output logic svc_fail_q, // Service failure mode
   // Write-back
   output logic wb_valid_q, // Write-back of evicted line
   output logic [err_pkg::IDX_W-1:0] wb_idx_q, // Line written back
   output logic wb_poison_q // Write-back carries poison
);
   import err_pkg::*;

   // ****************************************************************
   // Classification
   // ****************************************************************
   logic acc_def_able;
   logic acc_ce_w;
   logic acc_de_w;
   logic acc_ue_w;
   logic acc_rpt_w;
   logic cons_de_w;
   logic cons_ue_w;
   logic [NCLS-1:0] hit;

   // Deferral needs the consumer to take poison on reads
   assign acc_def_able = acc_defer_ok & (~acc_read | cons_poison_ok);
   assign acc_ce_w = acc_valid & acc_ce & ~acc_uncorr;
   assign acc_de_w = acc_valid & acc_uncorr & acc_def_able;
   assign acc_ue_w = acc_valid & acc_uncorr & ~acc_def_able;
   // Speculative detections are reported only when asked
   assign acc_rpt_w = ~acc_spec | rpt_spec_en;
   // Error or poison returned to our own transactions
   assign cons_ue_w = rsp_valid & rsp_err;
   assign cons_de_w = rsp_valid & rsp_poison & ~rsp_err;

   // Corrected reporting is optional, the rest reported unless a speculative access with rpt_spec_en low
   assign hit[CLS_CE] = acc_ce_w & acc_rpt_w & rpt_ce_en;
   assign hit[CLS_DE] = (acc_de_w & acc_rpt_w) | cons_de_w;
   // Deviation, lost poison and coherency loss are uncorrected
   assign hit[CLS_UE] = (acc_ue_w & acc_rpt_w) | cons_ue_w | dev_err
                        | poison_drop
                        | coh_loss;

   // ****************************************************************
   // Syndromes
   // ****************************************************************
   logic [SYN_W-1:0] syn_new [NCLS];
   logic [3:0] ue_cause;
   logic [ADDR_W-1:0] ue_addr;

   // Most specific cause wins when several share a cycle
   assign ue_cause = coh_loss ? CAUSE_COH_LOSS :
                     poison_drop ? CAUSE_POISON_LOST :
                     dev_err ? CAUSE_DEVIATION :
                     cons_ue_w ? CAUSE_CONS_ABORT : CAUSE_UNCORR;
   assign ue_addr = (coh_loss | poison_drop | dev_err) ? det_addr :
                    cons_ue_w ? rsp_addr : acc_addr;
   // Source id identifies us to a shared record
   assign syn_new[CLS_CE] = {SRC_ID, CAUSE_CORR, acc_addr};
   assign syn_new[CLS_DE] = acc_de_w ? {SRC_ID, CAUSE_DEFER, acc_addr}
                                     : {SRC_ID, CAUSE_CONS_POISON, rsp_addr};
   assign syn_new[CLS_UE] = {SRC_ID, ue_cause, ue_addr};

   // ****************************************************************
   // Pending classes and arbitration
   // ****************************************************************
   logic [NCLS-1:0] pend_q;
   logic [NCLS-1:0] pend_d;
   logic [SYN_W-1:0] syn_q [NCLS];
   logic [SYN_W-1:0] syn_d [NCLS];
   logic [NCLS-1:0] gnt;
   err_state_e gnt_state;
   logic [SYN_W-1:0] gnt_syn;

   severity_pick u_pick (
      .pend(pend_q),
      .gnt(gnt),
      .state(gnt_state)
   );

   assign gnt_syn = gnt[CLS_UE] ? syn_q[CLS_UE] : gnt[CLS_DE] ? syn_q[CLS_DE] : syn_q[CLS_CE];

   // New event wins over grant and recovery reset; latest syndrome kept
   always_comb begin
      for (int i = 0; i < NCLS; i++) begin
         pend_d[i] = hit[i] | (pend_q[i] & ~gnt[i] & ~err_rec_rst);
         syn_d[i] = hit[i] ? syn_new[i] : syn_q[i];
      end
   end

   // Pending flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= '0;
         for (int i = 0; i < NCLS; i++) begin
            syn_q[i] <= RST_SYN;
         end
      end else begin
         pend_q <= pend_d;
         syn_q <= syn_d;
      end
   end

   // ****************************************************************
   // Report and interrupts
   // ****************************************************************
   logic rpt_valid_d;
   logic fault_irq_d;
   logic recov_irq_d;

   // One report per cycle; interrupts ride along with the report
   assign rpt_valid_d = |gnt;
   assign fault_irq_d = rpt_valid_d & fhi_en;
   assign recov_irq_d = (gnt[CLS_DE] | gnt[CLS_UE]) & eri_en;

   // Report flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rpt_valid_q <= 1'b0;
         rpt_state_q <= ST_NONE;
         rpt_syn_q <= RST_SYN;
         fault_irq_q <= 1'b0;
         recov_irq_q <= 1'b0;
      end else begin
         rpt_valid_q <= rpt_valid_d;
         rpt_state_q <= gnt_state;
         rpt_syn_q <= gnt_syn;
         fault_irq_q <= fault_irq_d;
         recov_irq_q <= recov_irq_d;
      end
   end

   // ****************************************************************
   // Error record
   // ****************************************************************
   logic rec_valid_d;

   // Capture wins over clear; recovery reset does not touch it
   assign rec_valid_d = rpt_valid_q | (rec_valid_q & ~rec_clr);

   // Only power-on reset clears the syndrome, so it outlives recovery
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rec_valid_q <= 1'b0;
         rec_state_q <= ST_NONE;
         rec_syn_q <= RST_SYN;
      end else begin
         rec_valid_q <= rec_valid_d;
         if (rpt_valid_q) begin
            rec_state_q <= rpt_state_q;
            rec_syn_q <= rpt_syn_q;
         end
      end
   end

   // ****************************************************************
   // Service failure and consumer answers
   // ****************************************************************
   logic svc_fail_d;
   logic rd_w;
   logic rd_err_d;
   logic [DATA_W-1:0] rd_data_d;

   // Halt until recovery; a fresh fatal error wins over recovery
   assign svc_fail_d = (hit[CLS_UE] & halt_on_ue) | (svc_fail_q & ~err_rec_rst);
   assign rd_w = acc_valid & acc_read;
   // While halted every read is refused in-band
   assign rd_err_d = rd_w & ((acc_ue_w & inband_en) | svc_fail_q);
   // Error data is zeroed; an uncorrected read with inband_en low returns raw acc_data
   assign rd_data_d = rd_err_d ? RST_DATA : acc_ce_w ? acc_corr_data : acc_data;

   // Answer flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         svc_fail_q <= 1'b0;
         rd_valid_q <= 1'b0;
         rd_data_q <= RST_DATA;
         rd_poison_q <= 1'b0;
         rd_err_q <= 1'b0;
         poison_set_q <= 1'b0;
         poison_addr_q <= RST_ADDR;
      end else begin
         svc_fail_q <= svc_fail_d;
         rd_valid_q <= rd_w;
         rd_data_q <= rd_data_d;
         rd_poison_q <= rd_w & acc_de_w & ~svc_fail_q;
         rd_err_q <= rd_err_d;
         poison_set_q <= acc_de_w & ~acc_read;
         poison_addr_q <= acc_addr;
      end
   end

   // ****************************************************************
   // Cache line poison tracking
   // ****************************************************************
   logic [LINES-1:0] line_poison;
   logic [LINES-1:0] line_mod;
   logic ev_mod_w;
   logic ev_poison_w;

   for (genvar g = 0; g < LINES; g++) begin : g_line
      logic sel;
      assign sel = (line_idx == IDX_W'(g));
      line_poison_state u_line (
         .mclk(mclk),
         .rst_n(rst_n),
         .fill(fill_valid & sel),
         .fill_poison(fill_poison),
         .wr(pwr_valid & sel),
         .wr_full(pwr_full),
         .evict(evict_valid & sel),
         .poison_q(line_poison[g]),
         .modified_q(line_mod[g])
      );
   end

   // Only owned lines go back; clean ones must not be written
   assign ev_mod_w = evict_valid & ~fill_valid & ~pwr_valid & line_mod[line_idx];
   assign ev_poison_w = line_poison[line_idx];

   // Write-back flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wb_valid_q <= 1'b0;
         wb_idx_q <= RST_IDX;
         wb_poison_q <= 1'b0;
      end else begin
         wb_valid_q <= ev_mod_w;
         wb_idx_q <= line_idx;
         wb_poison_q <= ev_mod_w & ev_poison_w;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_CE_DATA: assert property (
      (rd_w && acc_ce_w && !svc_fail_q) |=>
         (rd_valid_q && rd_data_q == $past(acc_corr_data) && !rd_poison_q && !rd_err_q))
      else $error("corrected read did not return corrected data");

   AST_DE_POISON: assert property (
      (rd_w && acc_de_w && !svc_fail_q) |=> (rd_poison_q && !rd_err_q))
      else $error("deferred read not returned poisoned");

   AST_NO_DEFER: assert property (
      (rd_w && acc_uncorr && !cons_poison_ok) |=> !rd_poison_q)
      else $error("poison sent to consumer that refuses it");

   AST_UE_INBAND: assert property (
      (rd_w && acc_ue_w && inband_en) |=> (rd_err_q && rd_data_q == RST_DATA))
      else $error("uncorrected read missed in-band error");

   AST_UE_REPORT: assert property (
      hit[CLS_UE] |-> ##2 (rpt_valid_q && rpt_state_q == ST_UE))
      else $error("uncorrected error not reported in two cycles");

   AST_ORDER: assert property (
      (pend_q[CLS_DE] && pend_q[CLS_CE] && !pend_q[CLS_UE]) |=> (rpt_state_q == ST_DE))
      else $error("deferred error not reported before corrected");

   AST_IRQ: assert property (
      (rpt_valid_q && rpt_state_q != ST_CE && $past(fhi_en) && $past(eri_en)) |->
         (fault_irq_q && recov_irq_q))
      else $error("interrupts missing for deferred or uncorrected");

   AST_ERI_CE: assert property (
      recov_irq_q |-> (rpt_valid_q && rpt_state_q != ST_CE))
      else $error("recovery interrupt raised for corrected error");

   AST_RECORD: assert property (
      rpt_valid_q |=> (rec_valid_q && rec_syn_q == $past(rpt_syn_q)))
      else $error("report not captured in record");

   AST_KEEP: assert property (
      (err_rec_rst && !rpt_valid_q) |=> $stable(rec_syn_q))
      else $error("record lost over error recovery reset");

   AST_POISON_WB: assert property (
      (evict_valid && !fill_valid && !pwr_valid && line_poison[line_idx]
       && line_mod[line_idx]) |=> (wb_valid_q && wb_poison_q))
      else $error("poisoned owned line evicted without poison");

   AST_HALT: assert property (
      (hit[CLS_UE] && halt_on_ue) |=> svc_fail_q ##1 (!rd_valid_q || rd_err_q))
      else $error("service failure mode not entered");
endmodule
`default_nettype wire

// [test/record_node_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Recording node on the far side
// ******************************
module record_node_model
   import err_pkg::*;
(
   input wire logic mclk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic rpt_valid_q, // Report pulse
   input var err_pkg::err_state_e rpt_state_q, // Reported state
   input wire logic [err_pkg::SYN_W-1:0] rpt_syn_q, // Reported syndrome
   output var err_pkg::err_state_e node_state_q, // Held state
   output var logic [err_pkg::SYN_W-1:0] node_syn_q, // Held syndrome
   output var int node_cnt_q // Reports taken
);
   // One shared record; no recovery reset reaches it, so it survives one
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         node_state_q <= ST_NONE;
         node_syn_q <= RST_SYN;
         node_cnt_q <= 0;
      end else if (rpt_valid_q) begin
         node_state_q <= rpt_state_q;
         node_syn_q <= rpt_syn_q;
         node_cnt_q <= node_cnt_q + 1;
      end
   end
endmodule
`default_nettype wire

// [test/tb_error_detect_classify_report.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_error_detect_classify_report;
   import err_pkg::*;
   typedef struct {int c; logic v; logic [31:0] d; logic p, e, ps; logic [7:0] pa; logic dc;} rd_s;
   typedef struct {int c; logic [1:0] st; logic [15:0] syn; logic f, r;} rp_s;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic err_rec_rst, acc_valid, acc_read, acc_spec, acc_ce, acc_uncorr, acc_defer_ok;
   logic cons_poison_ok, rsp_valid, rsp_err, rsp_poison, dev_err, poison_drop, coh_loss;
   logic fill_valid, fill_poison, pwr_valid, pwr_full, evict_valid, rpt_ce_en, rpt_spec_en;
   logic fhi_en, eri_en, inband_en, halt_on_ue, rec_clr, halted, pz;
   logic [ADDR_W-1:0] acc_addr, rsp_addr, det_addr, poison_addr_q;
   logic [DATA_W-1:0] acc_data, acc_corr_data, rd_data_q;
   logic [IDX_W-1:0] line_idx, wb_idx_q;
   logic rd_valid_q, rd_poison_q, rd_err_q, poison_set_q, rpt_valid_q, fault_irq_q, recov_irq_q;
   logic rec_valid_q, svc_fail_q, wb_valid_q, wb_poison_q;
   logic [SYN_W-1:0] rpt_syn_q, rec_syn_q, node_syn_q, last;
   logic [1:0] last_st;
   err_state_e rpt_state_q, rec_state_q, node_state_q;
   int node_cnt_q, rec_c, tot, error_cnt, num_checks;
   int cyc = 0;
   logic [3:0] en;
   rd_s exp_rd[$];
   rp_s exp_rpt[$];
   rd_s mr;
   rp_s mq;

   error_detect_classify_report dut (.*);
   record_node_model node (.*);

   // Free-running 125 MHz clock
   always #4 mclk = ~mclk;

   // ****************
   // Checks and model
   // ****************
   task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Severity class of a consumer access, 0 when clean
   function automatic logic [1:0] cls(logic rd, ce, unc, dok, pok);
      if (unc) return (dok && (!rd || pok)) ? 2'h2 : 2'h3;
      return ce ? 2'h1 : 2'h0;
   endfunction

   function automatic void pr(int c, logic [1:0] st, logic [3:0] cs, logic [7:0] a);
      exp_rpt.push_back('{c, st, {SRC_ID, cs, a}, en[0], en[1] && st[1]});
      tot++;
   endfunction

   // Every pulse input dropped; spec, spec report and record clear stay low
   task automatic idle();
      {err_rec_rst, acc_valid, acc_read, acc_spec, acc_ce, acc_uncorr, acc_defer_ok} <= '0;
      {cons_poison_ok, rsp_valid, rsp_err, rsp_poison, dev_err, poison_drop, coh_loss} <= '0;
      {fill_valid, fill_poison, pwr_valid, pwr_full, evict_valid, rpt_spec_en, rec_clr} <= '0;
      {acc_addr, rsp_addr, det_addr, acc_data, acc_corr_data, line_idx} <= '0;
   endtask

   // Enables are held across a scenario so pending reports see stable values
   task automatic rnd_en();
      // Corrected reporting forced on while a poisoned response rides along
      en = 4'($urandom) | {pz, 3'h0};
      {inband_en, rpt_ce_en, eri_en, fhi_en} <= {en[2], en[3], en[1], en[0]};
   endtask

   // Gap after each request lets all reports drain
   task automatic go();
      @(posedge mclk);
      idle();
      repeat (5) @(posedge mclk);
   endtask

   task automatic access(logic rd, ce, unc, dok, pok, co);
      logic [1:0] st;
      logic [DATA_W-1:0] raw, cd;
      logic [ADDR_W-1:0] a, b;
      logic sp, se, rp;
      rd_s r;
      rnd_en();
      {raw, cd, a, b} = {$urandom, $urandom, 16'($urandom)};
      {sp, se} = {1'($urandom) & ~pz, 1'($urandom)};
      // Speculative access errors only reach the node when asked for
      rp = !sp || se;
      st = cls(rd, ce, unc, dok, pok);
      r = '{default: 0};
      r.c = cyc + 2;
      r.v = rd;
      r.e = rd && (halted || (st == 2'h3 && en[2]));
      r.d = r.e ? '0 : (st == 2'h1 ? cd : raw);
      r.dc = r.e || st != 2'h3;
      r.p = rd && st == 2'h2;
      r.ps = !rd && st == 2'h2;
      r.pa = a;
      if (rd || r.ps) exp_rd.push_back(r);
      {acc_valid, acc_read, acc_ce, acc_uncorr, acc_defer_ok} <= {1'b1, rd, ce, unc, dok};
      {cons_poison_ok, acc_addr, acc_data, acc_corr_data} <= {pok, a, raw, cd};
      {coh_loss, det_addr} <= {co, b};
      {acc_spec, rpt_spec_en, rsp_valid, rsp_poison, rsp_addr} <= {sp, se, pz, pz, b};
      if (co) pr(cyc + 3, 2'h3, CAUSE_COH_LOSS, b);
      if (pz) pr(cyc + 3 + co, 2'h2, CAUSE_CONS_POISON, b);
      if (st == 2'h3 && rp) pr(cyc + 3 + co, st, CAUSE_UNCORR, a);
      if (st == 2'h2 && rp) pr(cyc + 3 + co, st, CAUSE_DEFER, a);
      if (st == 2'h1 && en[3] && rp) pr(cyc + 3 + co + pz, st, CAUSE_CORR, a);
      go();
   endtask

   // Detector and response events, one kind per call
   task automatic ev(int k);
      logic [3:0] cs[5] = '{CAUSE_DEVIATION, CAUSE_POISON_LOST, CAUSE_COH_LOSS,
                            CAUSE_CONS_ABORT, CAUSE_CONS_POISON};
      logic [ADDR_W-1:0] a;
      rnd_en();
      a = ADDR_W'($urandom);
      {dev_err, poison_drop, coh_loss, det_addr} <= {k == 0, k == 1, k == 2, a};
      {rsp_valid, rsp_err, rsp_poison, rsp_addr} <= {k > 2, k == 3, k == 4, a};
      pr(cyc + 3, k == 4 ? 2'h2 : 2'h3, cs[k], a);
      go();
   endtask

   task automatic lop(logic f, fp, w, wf, e, logic [1:0] li, logic ew, ep);
      {fill_valid, fill_poison, pwr_valid, pwr_full} <= {f, fp, w, wf};
      {evict_valid, line_idx} <= {e, li};
      @(posedge mclk);
      idle();
      #1;
      chk("wb_valid", wb_valid_q, ew);
      if (ew) chk("wb_idx", wb_idx_q, li);
      if (ew) chk("wb_poison", wb_poison_q, ep);
      @(posedge mclk);
   endtask

   // ***********************************
   // Cycle-exact monitor of read, poison-set, record and report answers
   // ***********************************
   always @(posedge mclk) begin
      #1;
      cyc++;
      mr = '{default: 0};
      mq = '{default: 0};
      if (exp_rd.size() > 0 && exp_rd[0].c == cyc) mr = exp_rd.pop_front();
      if (exp_rpt.size() > 0 && exp_rpt[0].c == cyc) mq = exp_rpt.pop_front();
      chk("rd_valid", rd_valid_q, mr.v);
      if (mr.v) chk("rd_err", rd_err_q, mr.e);
      if (mr.v) chk("rd_poison", rd_poison_q, mr.p);
      if (mr.v && mr.dc) chk("rd_data", rd_data_q, mr.d);
      chk("poison_set", poison_set_q, mr.ps);
      if (mr.ps) chk("poison_addr", poison_addr_q, mr.pa);
      if (cyc == rec_c) chk("rec_valid", rec_valid_q, 1);
      if (cyc == rec_c) chk("rec_syn", rec_syn_q, last);
      if (cyc == rec_c) chk("rec_state", rec_state_q, last_st);
      chk("rpt_valid", rpt_valid_q, mq.st != 2'h0);
      if (mq.st != 2'h0) begin
         chk("rpt_state", rpt_state_q, mq.st);
         chk("rpt_syn", rpt_syn_q, mq.syn);
         chk("fault_irq", fault_irq_q, mq.f);
         chk("recov_irq", recov_irq_q, mq.r);
         last = mq.syn;
         last_st = mq.st;
         rec_c = cyc + 1;
      end
   end

   // Hang guard, far beyond the few hundred cycles of the run
   initial begin
      #40000;
      error_cnt++;
      wrap_up();
   end

   // **************
   // Main sequence
   // **************
   initial begin
      void'($urandom(79));
      {halted, pz, rec_c} = '0;
      halt_on_ue <= 1'b0;
      idle();
      rnd_en();
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      chk("svc_fail", svc_fail_q, 0);
      chk("rec_valid", rec_valid_q, 0);
      @(posedge mclk);
      for (int i = 0; i < 32; i++) access(i[0], i[1], i[2], i[3], i[4], 1'b0);
      access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      access(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      // Poisoned response beside a corrected read: UE, then DE, then CE
      pz = 1'b1;
      access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      pz = 1'b0;
      for (int k = 0; k < 5; k++) ev(k);
      for (int i = 0; i < 3; i++) begin
         lop(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'(i), 1'b0, 1'b0);
         if (i < 2) lop(1'b0, 1'b0, 1'b1, i[0], 1'b0, 2'(i), 1'b0, 1'b0);
         lop(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'(i), i < 2, i == 0);
      end
      halt_on_ue <= 1'b1;
      ev(2);
      chk("svc_fail", svc_fail_q, 1);
      halted = 1'b1;
      access(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      {halt_on_ue, err_rec_rst} <= 2'h3;
      halted = 1'b0;
      go();
      chk("svc_fail", svc_fail_q, 0);
      chk("rec_syn", rec_syn_q, last);
      chk("node_syn", node_syn_q, last);
      chk("node_state", node_state_q, last_st);
      chk("node_cnt", node_cnt_q, tot);
      chk("left", exp_rd.size() + exp_rpt.size(), 0);
      // Clear drops the valid flag only; syndrome stays readable
      rec_clr <= 1'b1;
      go();
      chk("rec_valid", rec_valid_q, 0);
      chk("rec_syn", rec_syn_q, last);
      wrap_up();
   end
endmodule
`default_nettype wire
